/* File: verilog/dcdma_pkg.sv */
// shared constants, register layout and carrier types of the dual channel transfer controller
package dcdma_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // i/o space offsets (low address byte)
    localparam logic [7:0] ADDR_CNT0_LO = 8'h26;
    localparam logic [7:0] ADDR_CNT0_HI = 8'h27;
    localparam logic [7:0] ADDR_CNT1_LO = 8'h2E;
    localparam logic [7:0] ADDR_CNT1_HI = 8'h2F;
    localparam logic [7:0] ADDR_STAT    = 8'h30;
    localparam logic [7:0] ADDR_MODE    = 8'h31;
    localparam logic [7:0] ADDR_WAIT    = 8'h32;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // dma_enable_status bit positions
    localparam int STAT_CH1_EN    = 7;
    localparam int STAT_CH0_EN    = 6;
    localparam int STAT_CH1_GUARD = 5;
    localparam int STAT_CH0_GUARD = 4;
    localparam int STAT_CH1_IE    = 3;
    localparam int STAT_CH0_IE    = 2;
    localparam int STAT_MASTER    = 0;

    // dma_mode_ch0 bit positions
    localparam int MODE_DST_HI = 5;
    localparam int MODE_DST_LO = 4;
    localparam int MODE_SRC_HI = 3;
    localparam int MODE_SRC_LO = 2;
    localparam int MODE_BURST  = 1;

    // dma_wait_control bit positions
    localparam int WAIT_MEM_HI = 7;
    localparam int WAIT_MEM_LO = 6;
    localparam int WAIT_IO_HI  = 5;
    localparam int WAIT_IO_LO  = 4;
    localparam int WAIT_SENSE_A = 3;
    localparam int WAIT_SENSE_B = 2;
    localparam int WAIT_DIR_HI = 1;
    localparam int WAIT_DIR_LO = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // channel 0 address mode encodings
    localparam logic [1:0] AM_INC     = 2'h0;
    localparam logic [1:0] AM_DEC     = 2'h1;
    localparam logic [1:0] AM_MEM_FIX = 2'h2;
    localparam logic [1:0] AM_IO_FIX  = 2'h3;

    // address step seen by the address engine
    localparam logic [1:0] STEP_INC = 2'h0;
    localparam logic [1:0] STEP_DEC = 2'h1;
    localparam logic [1:0] STEP_FIX = 2'h2;

    // channel 1 direction encodings
    localparam logic [1:0] CH1_M2IO_INC = 2'h0;
    localparam logic [1:0] CH1_M2IO_DEC = 2'h1;
    localparam logic [1:0] CH1_IO2M_INC = 2'h2;
    localparam logic [1:0] CH1_IO2M_DEC = 2'h3;

    localparam int         NUM_CH    = 2;
    localparam int         CNT_W     = 16;
    localparam logic [1:0] WAIT_RST  = 2'h3;
    localparam logic [15:0] CNT_ONE  = 16'h0001;
    localparam logic [15:0] CNT_TWO  = 16'h0002;
    localparam logic [15:0] CNT_RST  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic ch1_en;
        logic ch0_en;
        logic ch1_ie;
        logic ch0_ie;
        logic master;
    } dcdma_stat_t;

    typedef struct packed {
        logic [1:0] dst;
        logic [1:0] src;
        logic       burst;
    } dcdma_mode_t;

    typedef struct packed {
        logic [1:0] mem_wait;
        logic [1:0] io_wait;
        logic       req_sense_a;
        logic       req_sense_b;
        logic [1:0] ch1_dir;
    } dcdma_wait_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } dcdma_io_t;

    typedef struct packed {
        logic       src_io;
        logic       dst_io;
        logic [1:0] src_step;
        logic [1:0] dst_step;
    } dcdma_path_t;

    typedef struct packed {
        logic       to_io;
        logic [1:0] mem_step;
    } dcdma_ch1_t;

    localparam dcdma_stat_t STAT_RST = '{default: 1'b0};
    localparam dcdma_mode_t MODE_RST = '{default: '0};
    localparam dcdma_wait_t WAIT_RSTV = '{mem_wait: WAIT_RST, io_wait: WAIT_RST,
                                          req_sense_a: 1'b0, req_sense_b: 1'b0,
                                          ch1_dir: CH1_M2IO_INC};
    localparam dcdma_path_t PATH_RST = '{default: '0};
    localparam dcdma_ch1_t  CH1_RST  = '{default: '0};

endpackage

/* File: verilog/dcdma_req.sv */
// request pin detector: level or falling-edge sensing for one channel
`timescale 1ns/10ps
module dcdma_req (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic req_n,
    input  wire logic edge_mode,
    input  wire logic consume,
    output logic      pending
);
    import dcdma_pkg::*;

    logic prev_reg;
    logic prev_next;
    logic latch_reg;
    logic latch_next;
    logic fall;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        fall       = prev_reg & ~req_n;
        prev_next  = req_n;
        latch_next = latch_reg;
        if (consume) begin
            latch_next = 1'b0;
        end
        // a new edge in the consuming cycle is kept
        if (fall) begin
            latch_next = 1'b1;
        end
        if (!edge_mode) begin
            latch_next = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prev_reg  <= 1'b1;
            latch_reg <= 1'b0;
        end else begin
            prev_reg  <= prev_next;
            latch_reg <= latch_next;
        end
    end

    assign pending = edge_mode ? latch_reg : ~req_n;

endmodule

/* File: verilog/dcdma_cnt.sv */
// sixteen bit byte counter of one channel, byte-loadable from the i/o space
`timescale 1ns/10ps
module dcdma_cnt (
    input  wire logic                         clock,
    input  wire logic                         rst_n,
    input  wire logic                         load_lo,
    input  wire logic                         load_hi,
    input  wire logic [7:0]                   wdata,
    input  wire logic                         dec,
    output logic      [dcdma_pkg::CNT_W-1:0]  count
);
    import dcdma_pkg::*;

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        cnt_next = cnt_reg;
        if (dec) begin
            cnt_next = cnt_reg - CNT_ONE;
        end
        // a software load overrides the running count in the byte it writes; the other byte keeps the decremented value
        if (load_lo) begin
            cnt_next[7:0] = wdata;
        end
        if (load_hi) begin
            cnt_next[15:8] = wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= CNT_RST;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign count = cnt_reg;

endmodule

/* File: verilog/dcdma_ctrl.sv */
// two channel transfer controller: enable/status, mode and wait registers plus sequencer
//
// How it works
// - a channel runs only while its enable and the master enable are both set
// - the channel enable clears itself when its byte count reaches zero
// - interrupt request whenever a channel enable is 0 and its interrupt enable 1
// - enable bits are written only when the same write carries 0 in their guard bit
// - guard bits are not stored and always read back as 1
// - writing 1 to any channel enable also sets the master enable
// - writing 0 to a channel enable stops it; writing 1 restarts it
// - master enable is not directly writable; set by enable writes, cleared by nmi
// - nmi clears the master enable, suspending all channel activity
// - reset clears both enables, both interrupt enables and the master enable
// - channel 0 destination field decodes to inc, dec, fixed memory, fixed i/o
// - channel 0 source field decodes the same four ways
// - only twelve combinations valid; destination 1x with source 1x is reserved
// - memory to memory ignores the request pin; burst bit picks burst or steal
// - burst holds the bus to the end; steal gives the cpu two clock cycles per byte
// - i/o channel 0 paced by its request pin, burst bit ignored; modes reset to 0
// - memory wait field sets memory wait states; resets to all ones
// - i/o wait field sets i/o wait states; resets to all ones
// - each request sense bit picks level (0) or edge (1); both reset to 0
// - channel 1 field picks memory-to-i/o or i/o-to-memory, inc or dec
// - each byte count decrements by one per byte moved
// - channel 0 wins when both channels want service together
`timescale 1ns/10ps
module dcdma_ctrl (
    input  wire logic                    clock,
    input  wire logic                    rst_n,
    input  wire logic                    nmi_event,
    input  wire dcdma_pkg::dcdma_io_t    io,
    output logic      [7:0]              io_rdata,
    input  wire logic                    xfer_request_ch0_n,
    input  wire logic                    xfer_request_ch1_n,
    input  wire logic                    byte_done,
    output logic                         bus_hold,
    output logic                         xfer_ch,
    output logic                         last_xfer_flag_ch0_n,
    output dcdma_pkg::dcdma_path_t       ch0_path,
    output dcdma_pkg::dcdma_ch1_t        ch1_path,
    output logic      [1:0]              mem_wait,
    output logic      [1:0]              io_wait,
    output logic                         irq_ch0,
    output logic                         irq_ch1
);
    import dcdma_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CH0,
        ST_CH1,
        ST_GAP
    } dcdma_state_t;

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    dcdma_stat_t       stat_reg;
    dcdma_stat_t       stat_next;
    dcdma_mode_t       mode_reg;
    dcdma_mode_t       mode_next;
    dcdma_wait_t       wait_reg;
    dcdma_wait_t       wait_next;
    dcdma_state_t      state_reg;
    dcdma_state_t      state_next;
    dcdma_path_t       path_reg;
    dcdma_path_t       path_next;
    dcdma_ch1_t        ch1_reg;
    dcdma_ch1_t        ch1_next;
    logic [7:0]        rdata_reg;
    logic [7:0]        rdata_next;
    logic              hold_reg;
    logic              hold_next;
    logic              xch_reg;
    logic              xch_next;
    logic              tend_n_reg;
    logic              tend_n_next;
    logic              irq0_reg;
    logic              irq0_next;
    logic              irq1_reg;
    logic              irq1_next;

    logic [NUM_CH-1:0] req_pin_n;
    logic [NUM_CH-1:0] sense;
    logic [NUM_CH-1:0] pend;
    logic [NUM_CH-1:0] dec;
    logic [NUM_CH-1:0] load_lo;
    logic [NUM_CH-1:0] load_hi;
    logic [CNT_W-1:0]  cnt [NUM_CH];
    logic [NUM_CH-1:0] cnt_one;
    logic [NUM_CH-1:0] cnt_two;

    logic              wr_stat;
    logic              wr_mode;
    logic              wr_wait;
    logic              resv;
    logic              mem2mem;
    logic              run0;
    logic              run1;
    logic              ready0;
    logic              ready1;
    logic              term0;
    logic              term1;

    ////////////////////////////////////////////////////////////////////////////////
    // address decode

    assign wr_stat = io.wr & (io.addr == ADDR_STAT);
    assign wr_mode = io.wr & (io.addr == ADDR_MODE);
    assign wr_wait = io.wr & (io.addr == ADDR_WAIT);
    assign load_lo = {io.wr & (io.addr == ADDR_CNT1_LO), io.wr & (io.addr == ADDR_CNT0_LO)};
    assign load_hi = {io.wr & (io.addr == ADDR_CNT1_HI), io.wr & (io.addr == ADDR_CNT0_HI)};

    ////////////////////////////////////////////////////////////////////////////////
    // per channel request sense and byte counters

    assign req_pin_n = {xfer_request_ch1_n, xfer_request_ch0_n};
    assign sense     = {wait_reg.req_sense_b, wait_reg.req_sense_a};
    assign dec       = {byte_done & (state_reg == ST_CH1), byte_done & (state_reg == ST_CH0)};

    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
            dcdma_req u_req (
                .clock     (clock),
                .rst_n     (rst_n),
                .req_n     (req_pin_n[i]),
                .edge_mode (sense[i]),
                .consume   (dec[i]),
                .pending   (pend[i])
            );
            dcdma_cnt u_cnt (
                .clock   (clock),
                .rst_n   (rst_n),
                .load_lo (load_lo[i]),
                .load_hi (load_hi[i]),
                .wdata   (io.wdata),
                .dec     (dec[i]),
                .count   (cnt[i])
            );
            assign cnt_one[i] = (cnt[i] == CNT_ONE);
            assign cnt_two[i] = (cnt[i] == CNT_TWO);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // mode qualification

    assign resv    = mode_reg.dst[1] & mode_reg.src[1];
    assign mem2mem = (mode_reg.dst != AM_IO_FIX) & (mode_reg.src != AM_IO_FIX);
    assign run0    = stat_reg.ch0_en & stat_reg.master;
    assign run1    = stat_reg.ch1_en & stat_reg.master;
    // memory to memory needs no request; i/o is paced by the pin
    assign ready0  = run0 & ~resv & (mem2mem | pend[0]);
    assign ready1  = run1 & pend[1];
    // a count of one before the decrement means it has just reached zero
    assign term0   = dec[0] & cnt_one[0];
    assign term1   = dec[1] & cnt_one[1];

    ////////////////////////////////////////////////////////////////////////////////
    // enable / status register

    always_comb begin
        stat_next = stat_reg;
        if (term0) begin
            stat_next.ch0_en = 1'b0;
        end
        if (term1) begin
            stat_next.ch1_en = 1'b0;
        end
        if (wr_stat) begin
            if (!io.wdata[STAT_CH1_GUARD]) begin
                stat_next.ch1_en = io.wdata[STAT_CH1_EN];
            end
            if (!io.wdata[STAT_CH0_GUARD]) begin
                stat_next.ch0_en = io.wdata[STAT_CH0_EN];
            end
            stat_next.ch1_ie = io.wdata[STAT_CH1_IE];
            stat_next.ch0_ie = io.wdata[STAT_CH0_IE];
            if ((!io.wdata[STAT_CH1_GUARD] && io.wdata[STAT_CH1_EN]) ||
                (!io.wdata[STAT_CH0_GUARD] && io.wdata[STAT_CH0_EN])) begin
                stat_next.master = 1'b1;
            end
        end
        // nmi is applied last so it beats a simultaneous re-enable
        if (nmi_event) begin
            stat_next.master = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= STAT_RST;
        end else begin
            stat_reg <= stat_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // mode and wait control registers

    always_comb begin
        mode_next = mode_reg;
        wait_next = wait_reg;
        if (wr_mode) begin
            mode_next.dst   = io.wdata[MODE_DST_HI:MODE_DST_LO];
            mode_next.src   = io.wdata[MODE_SRC_HI:MODE_SRC_LO];
            mode_next.burst = io.wdata[MODE_BURST];
        end
        if (wr_wait) begin
            wait_next.mem_wait    = io.wdata[WAIT_MEM_HI:WAIT_MEM_LO];
            wait_next.io_wait     = io.wdata[WAIT_IO_HI:WAIT_IO_LO];
            wait_next.req_sense_a = io.wdata[WAIT_SENSE_A];
            wait_next.req_sense_b = io.wdata[WAIT_SENSE_B];
            wait_next.ch1_dir     = io.wdata[WAIT_DIR_HI:WAIT_DIR_LO];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= MODE_RST;
            wait_reg <= WAIT_RSTV;
        end else begin
            mode_reg <= mode_next;
            wait_reg <= wait_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // path decode for the address engine

    always_comb begin
        path_next.dst_io = (mode_reg.dst == AM_IO_FIX);
        path_next.src_io = (mode_reg.src == AM_IO_FIX);
        case (mode_reg.dst)
            AM_INC:  path_next.dst_step = STEP_INC;
            AM_DEC:  path_next.dst_step = STEP_DEC;
            default: path_next.dst_step = STEP_FIX;
        endcase
        case (mode_reg.src)
            AM_INC:  path_next.src_step = STEP_INC;
            AM_DEC:  path_next.src_step = STEP_DEC;
            default: path_next.src_step = STEP_FIX;
        endcase
        // i/o address of channel 1 is always fixed; only memory steps
        ch1_next.to_io = ~wait_reg.ch1_dir[1];
        case (wait_reg.ch1_dir)
            CH1_M2IO_INC: ch1_next.mem_step = STEP_INC;
            CH1_M2IO_DEC: ch1_next.mem_step = STEP_DEC;
            CH1_IO2M_INC: ch1_next.mem_step = STEP_INC;
            default:      ch1_next.mem_step = STEP_DEC;
        endcase
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            path_reg <= PATH_RST;
            ch1_reg  <= CH1_RST;
        end else begin
            path_reg <= path_next;
            ch1_reg  <= ch1_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transfer sequencer

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (ready0) begin
                    state_next = ST_CH0;
                end else if (ready1) begin
                    state_next = ST_CH1;
                end
            end
            ST_CH0: begin
                // a started byte always finishes; stops take effect at its end
                if (byte_done) begin
                    if (term0 || !run0) begin
                        state_next = ST_IDLE;
                    end else if (mem2mem && mode_reg.burst) begin
                        state_next = ST_CH0;
                    end else if (mem2mem) begin
                        state_next = ST_GAP;
                    end else begin
                        state_next = ST_IDLE;
                    end
                end
            end
            ST_CH1: begin
                if (byte_done) begin
                    state_next = ST_IDLE;
                end
            end
            ST_GAP: begin
                state_next = ST_IDLE;
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_comb begin
        hold_next   = (state_next == ST_CH0) || (state_next == ST_CH1);
        xch_next    = (state_next == ST_CH1);
        // low across the last byte of channel 0
        tend_n_next = ~((state_next == ST_CH0) && (dec[0] ? cnt_two[0] : cnt_one[0]));
        irq0_next   = ~stat_next.ch0_en & stat_next.ch0_ie;
        irq1_next   = ~stat_next.ch1_en & stat_next.ch1_ie;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= ST_IDLE;
            hold_reg   <= 1'b0;
            xch_reg    <= 1'b0;
            tend_n_reg <= 1'b1;
            irq0_reg   <= 1'b0;
            irq1_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            hold_reg   <= hold_next;
            xch_reg    <= xch_next;
            tend_n_reg <= tend_n_next;
            irq0_reg   <= irq0_next;
            irq1_reg   <= irq1_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read-back

    always_comb begin
        rdata_next = rdata_reg;
        if (io.rd) begin
            case (io.addr)
                ADDR_STAT: begin
                    rdata_next = 8'h30;
                    rdata_next[STAT_CH1_EN] = stat_reg.ch1_en;
                    rdata_next[STAT_CH0_EN] = stat_reg.ch0_en;
                    rdata_next[STAT_CH1_IE] = stat_reg.ch1_ie;
                    rdata_next[STAT_CH0_IE] = stat_reg.ch0_ie;
                    rdata_next[STAT_MASTER] = stat_reg.master;
                end
                ADDR_MODE: begin
                    rdata_next = 8'h00;
                    rdata_next[MODE_DST_HI:MODE_DST_LO] = mode_reg.dst;
                    rdata_next[MODE_SRC_HI:MODE_SRC_LO] = mode_reg.src;
                    rdata_next[MODE_BURST]              = mode_reg.burst;
                end
                ADDR_WAIT:    rdata_next = wait_reg;
                ADDR_CNT0_LO: rdata_next = cnt[0][7:0];
                ADDR_CNT0_HI: rdata_next = cnt[0][15:8];
                ADDR_CNT1_LO: rdata_next = cnt[1][7:0];
                ADDR_CNT1_HI: rdata_next = cnt[1][15:8];
                default:      rdata_next = READ_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= READ_UNMAPPED;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign io_rdata             = rdata_reg;
    assign bus_hold             = hold_reg;
    assign xfer_ch              = xch_reg;
    assign last_xfer_flag_ch0_n = tend_n_reg;
    assign ch0_path             = path_reg;
    assign ch1_path             = ch1_reg;
    assign mem_wait             = wait_reg.mem_wait;
    assign io_wait              = wait_reg.io_wait;
    assign irq_ch0              = irq0_reg;
    assign irq_ch1              = irq1_reg;

endmodule

/* File: bench/dcdma_bus_model.sv */
// memory and i/o side: ends each held byte promptly or slowly
`timescale 1ns/10ps
module dcdma_bus_model (
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic bus_hold,
    input  wire logic slow,
    output logic      byte_done
);
    int n;
    // a byte is only ever ended while the bus is held, never twice in a row
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            n <= 0;
            byte_done <= 1'b0;
        end else begin
            byte_done <= bus_hold && !byte_done && n >= (slow ? 3 : 0);
            n <= (bus_hold && !byte_done) ? n + 1 : 0;
        end
    end
endmodule

/* File: bench/dcdma_ctrl_monitor.sv */
// port checker for the transfer controller
`timescale 1ns/10ps
module dcdma_ctrl_monitor (
    input wire logic                   clock,
    input wire logic                   rst_n,
    input wire dcdma_pkg::dcdma_io_t   io,
    input wire logic                   byte_done,
    input wire logic                   bus_hold,
    input wire logic                   xfer_ch,
    input wire logic                   last_xfer_flag_ch0_n,
    input wire dcdma_pkg::dcdma_path_t ch0_path,
    input wire dcdma_pkg::dcdma_ch1_t  ch1_path,
    input wire logic [1:0]             mem_wait,
    input wire logic [1:0]             io_wait,
    input wire logic                   irq_ch0
);
    import dcdma_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_mode; io.wr && io.addr == ADDR_MODE; endsequence
    sequence s_wait; io.wr && io.addr == ADDR_WAIT; endsequence
    property p_mw; s_wait |=> {mem_wait, io_wait} == $past(io.wdata[7:4]); endproperty
    a_mw: assert property (p_mw) else $error("wait fields wrong");
    property p_dst; s_mode ##2 1'b1 |-> ch0_path.dst_io == ($past(io.wdata[5:4], 2) == AM_IO_FIX)
        && ch0_path.dst_step ==
           ($past(io.wdata[5], 2) ? STEP_FIX : {1'b0, $past(io.wdata[4], 2)});
    endproperty
    a_dst: assert property (p_dst) else $error("dest decode wrong");
    property p_src; s_mode ##2 1'b1 |-> ch0_path.src_io == ($past(io.wdata[3:2], 2) == AM_IO_FIX)
        && ch0_path.src_step ==
           ($past(io.wdata[3], 2) ? STEP_FIX : {1'b0, $past(io.wdata[2], 2)});
    endproperty
    a_src: assert property (p_src) else $error("source decode wrong");
    property p_dir; s_wait ##2 1'b1 |-> ch1_path.to_io == !$past(io.wdata[1], 2)
        && ch1_path.mem_step == {1'b0, $past(io.wdata[0], 2)};
    endproperty
    a_dir: assert property (p_dir) else $error("ch1 direction wrong");
    // the bus may only be given back once the current byte has ended
    property p_hold; bus_hold && !byte_done |=> bus_hold; endproperty
    a_hold: assert property (p_hold) else $error("bus dropped mid byte");
    property p_last; !last_xfer_flag_ch0_n |-> bus_hold && !xfer_ch; endproperty
    a_last: assert property (p_last) else $error("last flag out of place");
    property p_irq; $rose(irq_ch0) |-> $past(io.wr || byte_done); endproperty
    a_irq: assert property (p_irq) else $error("irq without cause");
    property p_xch; bus_hold && $past(bus_hold) |-> $stable(xfer_ch); endproperty
    a_xch: assert property (p_xch) else $error("owner changed while held");
endmodule
bind dcdma_ctrl dcdma_ctrl_monitor mon_u (.clock, .rst_n, .io, .byte_done, .bus_hold,
    .xfer_ch, .last_xfer_flag_ch0_n, .ch0_path, .ch1_path, .mem_wait, .io_wait, .irq_ch0);

/* File: bench/tb_top.sv */
// self-checking bench of the transfer controller
`timescale 1ns/10ps
`define CK(a, b) begin checked++; if ((a) !== (b)) begin err_total++; \
    $display("CHECK FAILED %0t %h %h", $time, a, b); end end
module tb_top;
    import dcdma_pkg::*;
    logic       clock = 0, rst_n = 0, nmi = 0, r0 = 1, r1 = 1, slow = 0, bd, hold, q0, q1;
    logic [1:0] mw, iw;
    logic [7:0] rdata;
    dcdma_io_t  io = '0;
    int         err_total, checked, seed = 39913, k, nb, w, en0, en1, ie0, ie1, mst;
    always #2.5 clock = ~clock;
    dcdma_ctrl dut_u (.clock, .rst_n, .nmi_event(nmi), .io, .io_rdata(rdata),
        .xfer_request_ch0_n(r0), .xfer_request_ch1_n(r1), .byte_done(bd), .bus_hold(hold),
        .xfer_ch(), .last_xfer_flag_ch0_n(), .ch0_path(), .ch1_path(), .mem_wait(mw),
        .io_wait(iw), .irq_ch0(q0), .irq_ch1(q1));
    dcdma_bus_model bus_u (.clock, .rst_n, .bus_hold(hold), .slow, .byte_done(bd));
    function logic [7:0] st;
        return {en1[0], en0[0], 2'b11, ie1[0], ie0[0], 1'b0, mst[0]};
    endfunction
    task wr(input logic [7:0] a, d);
        @(posedge clock) io <= '{a, 1'b1, 1'b0, d};
        @(posedge clock) io.wr <= 1'b0;
    endtask
    task rd(input logic [7:0] a, e);
        @(posedge clock) io <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clock) io.rd <= 1'b0;
        @(negedge clock) `CK(rdata, e)
    endtask
    // fixed window: long enough for the slowest transfer used here
    task win(input int n);
        nb = 0;
        repeat (60) @(posedge clock) nb += bd;
        `CK(nb, n)
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge clock);
        err_total++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        rd(ADDR_STAT, 8'h30);
        rd(ADDR_MODE, 8'h00);
        rd(ADDR_WAIT, 8'hF0);
        $display("reset test done");
        ie0 = 1;
        ie1 = 1;
        wr(ADDR_STAT, 8'hFD);
        rd(ADDR_STAT, st());
        `CK(q0, 1'b1)
        w = $random(seed);
        wr(ADDR_WAIT, w[7:0]);
        rd(ADDR_WAIT, w[7:0]);
        `CK({mw, iw}, w[7:4])
        // back to level sense, the paced scenarios below count on it
        wr(ADDR_WAIT, w[7:0] & 8'hF3);
        $display("register test done");
        for (k = 0; k < 16; k++) begin
            w = $random(seed);
            wr(ADDR_MODE, {2'h0, k[3:0], w[0], 1'b0});
            rd(ADDR_MODE, {2'h0, k[3:0], w[0], 1'b0});
            @(posedge clock) r0 <= !(k[3:2] == 2'h3 || k[1:0] == 2'h3);
            wr(ADDR_CNT0_LO, 8'h02);
            wr(ADDR_CNT0_HI, 8'h00);
            wr(ADDR_STAT, 8'h4C);
            en0 = k[3] & k[1];
            mst = 1;
            win(2 - 2 * en0);
            rd(ADDR_STAT, st());
            rd(ADDR_CNT0_LO, {6'h00, en0[0], 1'b0});
            wr(ADDR_STAT, 8'h2C);
            en0 = 0;
            rd(ADDR_STAT, st());
        end
        $display("mode test done");
        wr(ADDR_CNT1_LO, 8'h03);
        wr(ADDR_CNT1_HI, 8'h00);
        wr(ADDR_STAT, 8'h9C);
        en1 = 1;
        rd(ADDR_STAT, st());
        @(posedge clock) nmi <= 1'b1;
        @(posedge clock) nmi <= 1'b0;
        r1 <= 1'b0;
        slow <= 1'b1;
        mst = 0;
        rd(ADDR_STAT, st());
        win(0);
        wr(ADDR_STAT, 8'h9C);
        en1 = 0;
        mst = 1;
        win(3);
        rd(ADDR_STAT, st());
        `CK(q1, 1'b1)
        $display("nmi test done");
        wr(ADDR_WAIT, 8'h04);
        wr(ADDR_CNT1_LO, 8'h02);
        @(posedge clock) r1 <= 1'b1;
        @(posedge clock) r1 <= 1'b0;
        wr(ADDR_STAT, 8'h9C);
        win(1);
        rd(ADDR_CNT1_LO, 8'h01);
        $display("edge test done");
        close_out;
    end
endmodule
